// File: sdt_pkg.sv
// Package with register map, field layout and shared types of the six channel down timer.
package sdt_pkg;
   localparam int          SDT_NUM_TIMERS     = 6;
   localparam int          SDT_CNT_W          = 32;
   localparam int          SDT_FIELD_STRIDE   = 3;
   localparam int          SDT_FLD_ENABLE     = 0;
   localparam int          SDT_FLD_MODE       = 1;
   localparam int          SDT_FLD_INIT_LEVEL = 2;
   localparam int          SDT_MODE_USED_W    = 18;
   localparam int          SDT_IRQ_BASE_INDEX = 32;
   localparam logic [31:0] SDT_MODE_CTRL_ADDR = 32'hf0040000;
   localparam logic [7:0]  SDT_OFF_MODE_CTRL  = 8'h00;
   localparam logic [7:0]  SDT_OFF_INT_CLEAR  = 8'h04;
   localparam logic [7:0]  SDT_OFF_INT_STATUS = 8'h08;
   localparam logic [7:0]  SDT_OFF_INT_MASK   = 8'h0c;
   localparam logic [7:0]  SDT_OFF_BASE0      = 8'h10;
   localparam logic [7:0]  SDT_OFF_COUNT0     = 8'h30;
   localparam logic [31:0] SDT_MODE_RESET     = 32'h00000000;
   localparam logic [5:0]  SDT_MASK_RESET     = 6'h00;
   localparam logic [31:0] SDT_BASE_RESET     = 32'h00000000;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [31:0] adr;
      logic [31:0] dat;
   } sdt_wb_req_t;

   typedef struct packed {
      logic        enable;
      logic        toggle_mode;
      logic        init_level;
   } sdt_chan_cfg_t;
endpackage

// File: sdt_channel.sv
// One down counting timer channel with reload, interval pulse and toggle output.
`timescale 1ns/1ps
module sdt_channel
   import sdt_pkg::*;
#(
   parameter int CNT_W = SDT_CNT_W
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire sdt_chan_cfg_t    cfg_i,
   input  wire logic [CNT_W-1:0] base_value_i,
   output logic      [CNT_W-1:0] count_o,
   output logic                  timeout_o,
   output logic                  pin_o
);
   logic             run_reg;
   logic [CNT_W-1:0] count_reg;
   logic             level_reg;
   logic             pulse_reg;
   logic             expire;

   // The count runs base..1, so a time-out comes every base cycles.
   assign expire = run_reg && cfg_i.enable && (count_reg <= CNT_W'(1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         run_reg <= 1'b0;
      end else begin
         run_reg <= cfg_i.enable;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= '0;
      end else if (cfg_i.enable && !run_reg) begin
         count_reg <= base_value_i;
      end else if (expire) begin
         count_reg <= base_value_i;
      end else if (cfg_i.enable) begin
         count_reg <= count_reg - CNT_W'(1);
      end
      // A stopped timer keeps its count and does not reload here.
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_reg <= 1'b0;
      end else if (!cfg_i.enable) begin
         level_reg <= cfg_i.init_level;
      end else if (!run_reg) begin
         // The enable write lands together with a new initial level, so load it again here.
         level_reg <= cfg_i.init_level;
      end else if (expire) begin
         level_reg <= ~level_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pulse_reg <= 1'b0;
      end else begin
         pulse_reg <= expire;
      end
   end

   assign count_o   = count_reg;
   assign timeout_o = pulse_reg;
   assign pin_o     = cfg_i.toggle_mode ? level_reg : pulse_reg;
endmodule

// File: sdt_top.sv
// Six channel down timer with its Wishbone register file and interrupt logic.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
// How it works
// - Six independent 32-bit timers, each with base and count register and pin.
// - Interval mode gives one clock pulse per time-out, also the interrupt.
// - Interval mode output frequency is clock divided by base value.
// - Toggle mode inverts the output each time-out, giving 50% duty.
// - Toggle mode output frequency is clock divided by twice base value.
// - Toggle mode raises an interrupt at each output inversion.
// - Enabling copies base into count, then count decrements each clock.
// - At count-out raise interrupt, reload from base, keep counting.
// - Disabling a running timer does not reload its count.
// - One read/write mode register holds all settings, resets to zero.
// - Enable bits sit at 0, 3, 6, 9, 12, 15; one runs the timer.
// - Mode bits sit at 1, 4, 7, 10, 13, 16; one selects toggle.
// - Initial level bits sit at 2, 5, 8, 11, 14, 17.
// - Writing the interrupt clear register clears pending timer interrupts.
// - Timer interrupts feed controller sources 32 to 37 in order.
module sdt_top
   import sdt_pkg::*;
#(
   parameter int NUM_TIMERS = SDT_NUM_TIMERS,
   parameter int CNT_W      = SDT_CNT_W
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_adr_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   output logic                       wb_err_o,
   output logic      [NUM_TIMERS-1:0] timer_output_pin_o,
   output logic      [NUM_TIMERS-1:0] timer_irq_src_o,
   output logic                       irq_o
);
   sdt_wb_req_t                    req;
   logic        [31:0]             mode_control_register_reg;
   logic        [NUM_TIMERS-1:0]   int_status_reg;
   logic        [NUM_TIMERS-1:0]   int_mask_reg;
   logic        [CNT_W-1:0]        base_value_register_reg [NUM_TIMERS];
   logic        [CNT_W-1:0]        count_register [NUM_TIMERS];
   logic        [NUM_TIMERS-1:0]   timeout;
   logic                           ack_reg;
   logic                           err_reg;
   logic        [31:0]             rdata_reg;
   logic        [31:0]             rdata_next;
   logic                           hit;
   logic                           access;
   logic                           wr_stb;
   logic        [7:0]              offset;
   logic        [31:0]             wmask;
   logic        [31:0]             mode_used_mask;
   logic        [NUM_TIMERS-1:0]   clear_bits;

   assign req.cyc = wb_cyc_i;
   assign req.stb = wb_stb_i;
   assign req.we  = wb_we_i;
   assign req.sel = wb_sel_i;
   assign req.adr = wb_adr_i;
   assign req.dat = wb_dat_i;

   // The block occupies a 256 byte window starting at the mode register.
   assign offset = req.adr[7:0];
   assign hit    = (req.adr[31:8] == SDT_MODE_CTRL_ADDR[31:8]) && (offset[1:0] == 2'b00);
   // Access is blocked only while ack or err is high, so a held request is served again every second cycle.
   assign access = req.cyc && req.stb && !ack_reg && !err_reg;
   assign wr_stb = access && hit && req.we;
   assign wmask  = {{8{req.sel[3]}}, {8{req.sel[2]}}, {8{req.sel[1]}}, {8{req.sel[0]}}};
   assign mode_used_mask = {{(32-SDT_MODE_USED_W){1'b0}}, {SDT_MODE_USED_W{1'b1}}};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         ack_reg <= access && hit;
         err_reg <= access && !hit;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_control_register_reg <= SDT_MODE_RESET;
      end else if (wr_stb && offset == SDT_OFF_MODE_CTRL) begin
         mode_control_register_reg <= ((mode_control_register_reg & ~wmask) |
                                       (req.dat & wmask)) & mode_used_mask;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_mask_reg <= SDT_MASK_RESET;
      end else if (wr_stb && offset == SDT_OFF_INT_MASK && req.sel[0]) begin
         int_mask_reg <= req.dat[NUM_TIMERS-1:0];
      end
   end

   // Writing a one clears that pending bit; a time-out in the same cycle wins.
   always_comb begin
      clear_bits = '0;
      if (wr_stb && req.sel[0] &&
          (offset == SDT_OFF_INT_CLEAR || offset == SDT_OFF_INT_STATUS)) begin
         clear_bits = req.dat[NUM_TIMERS-1:0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         int_status_reg <= '0;
      end else begin
         int_status_reg <= (int_status_reg & ~clear_bits) | timeout;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_TIMERS; g++) begin : g_timer
         sdt_chan_cfg_t cfg;

         // Base values are writable at any time; changing one while running
         // takes effect at the next reload and may shorten a period.
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               base_value_register_reg[g] <= SDT_BASE_RESET;
            end else if (wr_stb && offset == SDT_OFF_BASE0 + 8'(4 * g)) begin
               base_value_register_reg[g] <= (base_value_register_reg[g] & ~wmask) |
                                             (req.dat & wmask);
            end
         end

         assign cfg.enable      = mode_control_register_reg[SDT_FIELD_STRIDE*g +
                                  SDT_FLD_ENABLE];
         assign cfg.toggle_mode = mode_control_register_reg[SDT_FIELD_STRIDE*g +
                                  SDT_FLD_MODE];
         assign cfg.init_level  = mode_control_register_reg[SDT_FIELD_STRIDE*g +
                                  SDT_FLD_INIT_LEVEL];

         sdt_channel #(
            .CNT_W(CNT_W)
         ) u_channel (
            .clk_i       (clk_i),
            .rst_i       (rst_i),
            .cfg_i       (cfg),
            .base_value_i(base_value_register_reg[g]),
            .count_o     (count_register[g]),
            .timeout_o   (timeout[g]),
            .pin_o       (timer_output_pin_o[g])
         );
      end
   endgenerate

   always_comb begin
      rdata_next = 32'h00000000;
      if (offset == SDT_OFF_MODE_CTRL) begin
         rdata_next = mode_control_register_reg;
      end else if (offset == SDT_OFF_INT_STATUS) begin
         rdata_next[NUM_TIMERS-1:0] = int_status_reg;
      end else if (offset == SDT_OFF_INT_MASK) begin
         rdata_next[NUM_TIMERS-1:0] = int_mask_reg;
      end else begin
         for (int i = 0; i < NUM_TIMERS; i++) begin
            if (offset == SDT_OFF_BASE0 + 8'(4 * i)) begin
               rdata_next = base_value_register_reg[i];
            end
            if (offset == SDT_OFF_COUNT0 + 8'(4 * i)) begin
               rdata_next = count_register[i];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_reg <= 32'h00000000;
      end else if (access && hit && !req.we) begin
         rdata_reg <= rdata_next;
      end
   end

   assign wb_dat_o        = rdata_reg;
   assign wb_ack_o        = ack_reg;
   assign wb_err_o        = err_reg;
   // Source i maps to controller index SDT_IRQ_BASE_INDEX + i.
   assign timer_irq_src_o = int_status_reg;
   assign irq_o           = |(int_status_reg & int_mask_reg);
endmodule

// File: sdt_intc_model.sv
// Interrupt controller model that maps timer requests onto its source indices.
`timescale 1ns/1ps
module sdt_intc_model
   import sdt_pkg::*;
(
   input  wire logic [SDT_NUM_TIMERS-1:0] src_i,
   output logic      [63:0]               pend_o
);
   always_comb begin
      pend_o = '0;
      pend_o[SDT_IRQ_BASE_INDEX +: SDT_NUM_TIMERS] = src_i;
   end
endmodule

// File: sdt_properties.sv
// Port level assertions for the six channel down timer.
`timescale 1ns/1ps
module sdt_properties
   import sdt_pkg::*;
#(
   parameter int NUM_TIMERS = SDT_NUM_TIMERS,
   parameter int CNT_W      = SDT_CNT_W
) (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire logic                  wb_cyc_i,
   input wire logic                  wb_stb_i,
   input wire logic                  wb_we_i,
   input wire logic [3:0]            wb_sel_i,
   input wire logic [31:0]           wb_adr_i,
   input wire logic [31:0]           wb_dat_i,
   input wire logic [31:0]           wb_dat_o,
   input wire logic                  wb_ack_o,
   input wire logic                  wb_err_o,
   input wire logic [NUM_TIMERS-1:0] timer_output_pin_o,
   input wire logic [NUM_TIMERS-1:0] timer_irq_src_o,
   input wire logic                  irq_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic        take;
   logic        ok;
   logic [31:0] mode_reg;
   assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign ok   = wb_adr_i[31:8] == SDT_MODE_CTRL_ADDR[31:8] && wb_adr_i[1:0] == 2'h0;
   // Shadow of the mode word; any write to it is copied whole, ignoring wb_sel_i.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_reg <= SDT_MODE_RESET;
      end else if (take && wb_we_i && wb_adr_i == SDT_MODE_CTRL_ADDR) begin
         mode_reg <= wb_dat_i;
      end
   end
   property p_ack_one;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack held too long");
   property p_ack_ok;
      take && ok |=> wb_ack_o && !wb_err_o;
   endproperty
   a_ack_ok: assert property (p_ack_ok) else $error("mapped access not acked");
   property p_err_bad;
      take && !ok |=> wb_err_o && !wb_ack_o;
   endproperty
   a_err_bad: assert property (p_err_bad) else $error("bad access not refused");
   property p_pulse_one;
      mode_reg[1:0] == 2'h1 && timer_output_pin_o[0] |=> !timer_output_pin_o[0];
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("pulse wider than one");
   property p_pulse_irq;
      mode_reg[1:0] == 2'h1 && timer_output_pin_o[0] |=> timer_irq_src_o[0];
   endproperty
   a_pulse_irq: assert property (p_pulse_irq) else $error("pulse without request");
   property p_idle_low;
      mode_reg[2:0] == 3'h0 [*3] |-> !timer_output_pin_o[0];
   endproperty
   a_idle_low: assert property (p_idle_low) else $error("idle pin not low");
   property p_irq_src;
      irq_o |-> timer_irq_src_o != '0;
   endproperty
   a_irq_src: assert property (p_irq_src) else $error("irq without source");
   property p_rst_zero;
      $fell(rst_i) |-> timer_irq_src_o == '0 && !irq_o && timer_output_pin_o == '0;
   endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("pins not idle");
   c_err: cover property (wb_err_o);
   c_pulse: cover property (timer_output_pin_o[0] && !mode_reg[1]);
   c_irq: cover property (irq_o);
endmodule

// File: tb_sdt_top.sv
// Self-checking bench for the six channel down timer.
`timescale 1ns/1ps
module tb_sdt_top;
   import sdt_pkg::*;
   logic        clk_i, rst_i, cyc, stb, we, ack, err, irq, e, b;
   logic [3:0]  sel;
   logic [31:0] adr, dat, rdat, seed, q, v, x;
   logic [5:0]  pin, src;
   logic [63:0] pend;
   int          num_errors, compares, n;
   int          cyc_cnt = 0;
   sdt_top u_sdt_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .wb_err_o(err), .timer_output_pin_o(pin), .timer_irq_src_o(src),
      .irq_o(irq));
   sdt_intc_model u_sdt_intc_model (.src_i(src), .pend_o(pend));
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] ra(input int o);
      return SDT_MODE_CTRL_ADDR + 32'(o);
   endfunction
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (!(ack || err));
      q = rdat;
      e = err;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [31:0] xp, input logic [31:0] g);
      compares++;
      if (g !== xp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", s, xp, g);
      end
   endtask
   // Counts cycles until pin g leaves its present level; bounded so a dead pin ends it.
   task automatic wch(input int g);
      logic lv;
      lv = pin[g];
      n = 0;
      do begin
         @(posedge clk_i);
         #1;
         n++;
      end while (pin[g] === lv && n < 64);
   endtask
   task automatic close_out();
      $display("num_errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      seed = 32'h6b78f296;
      {num_errors, compares} = '0;
      {cyc, stb, we, adr, dat} = '0;
      sel = 4'hf;
      rst_i = 1'b1;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(0, ra(0), 0);
      chk("mode reset", 32'h0, q);
      bus(1, ra(0), 32'hffff6db6);
      bus(0, ra(0), 0);
      chk("mode bits", 32'h36db6, q);
      bus(1, ra(0), 0);
      bus(0, 32'hf0040100, 0);
      chk("unmapped err", 1, e);
      bus(1, ra(12), 32'h3f);
      $display("register test done");
      for (int g = 0; g < 6; g++) begin
         v = 2 + rnd() % 8;
         bus(1, ra(16 + 4 * g), v);
         bus(1, ra(0), 32'h1 << (3 * g));
         wch(g);
         wch(g);
         chk("pulse width", 1, n);
         wch(g);
         chk("pulse period", v, n + 1);
         chk("irq src", 1, src[g]);
         chk("ctrl index", 1, pend[SDT_IRQ_BASE_INDEX + g]);
         chk("irq out", 1, irq);
         bus(1, ra(0), 0);
         bus(0, ra(48 + 4 * g), 0);
         x = q;
         bus(0, ra(48 + 4 * g), 0);
         chk("count frozen", x, q);
         bus(1, ra(4), 32'h1 << g);
         chk("irq cleared", 0, {src[g], irq});
         b = rnd() % 2;
         bus(1, ra(0), (b ? 32'h7 : 32'h3) << (3 * g));
         #1;
         chk("init level", b, pin[g]);
         wch(g);
         wch(g);
         chk("half period", v, n);
         wch(g);
         chk("other half", v, n);
         chk("toggle irq", 1, src[g]);
         bus(1, ra(0), 0);
         bus(1, ra(4), 32'h3f);
         $display("channel %0d done", g);
      end
      close_out();
   end
endmodule
bind sdt_top sdt_properties #(.NUM_TIMERS(NUM_TIMERS), .CNT_W(CNT_W)) u_sdt_properties (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
   .timer_output_pin_o(timer_output_pin_o), .timer_irq_src_o(timer_irq_src_o),
   .irq_o(irq_o));
